// ===== hdl/pio_cfg.svh
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// register addresses on the special-function-register bus
`define PIO_ADDR_LATCH 8'h80
`define PIO_ADDR_ROUTE0 8'h95
`define PIO_ADDR_ROUTE1 8'h96
`define PIO_ADDR_ADSEL 8'hF1
`define PIO_ADDR_OTYPE 8'hA4
`define PIO_ADDR_SKIP 8'hD4
`define PIO_ADDR_DRV 8'hF9
`define PIO_ADDR_MATCH 8'hF4
`define PIO_ADDR_MASK 8'h8B

// reset values
`define PIO_RST_LATCH 8'hFF
`define PIO_RST_ADSEL 8'hFF
`define PIO_RST_OTYPE 8'h00
`define PIO_RST_SKIP 8'h00
`define PIO_RST_DRV 8'h00
`define PIO_RST_MATCH 8'hFF
`define PIO_RST_MASK 8'h00
`define PIO_RST_ROUTE0 8'h00
`define PIO_RST_ROUTE1 8'h00

// first routing register fields
`define PIO_R0_ECI 7
`define PIO_R0_CEX_HI 6
`define PIO_R0_CEX_LO 4
`define PIO_R0_SYSCK 3
`define PIO_R0_TWOWIRE 2
`define PIO_R0_SPI 1
`define PIO_R0_UART 0

// second routing register fields
`define PIO_R1_PUOFF 7
`define PIO_R1_XBAR 6
`define PIO_R1_T1 1
`define PIO_R1_T0 0
`define PIO_R1_WMASK 8'hC3

// fixed pins of the async serial pair
`define PIO_UART_TX_PIN 4
`define PIO_UART_RX_PIN 5

`endif

// ===== hdl/pio_pkg.sv
package pio_pkg;

	// peripheral signals, crossbar priority order after the fixed pair
	typedef enum logic [3:0] {
		PIO_RES_TX,
		PIO_RES_RX,
		PIO_RES_SDA,
		PIO_RES_SCL,
		PIO_RES_SCK,
		PIO_RES_MISO,
		PIO_RES_MOSI,
		PIO_RES_NSS,
		PIO_RES_SYSCLK,
		PIO_RES_COUNTER_CHANNEL_OUTPUT,
		PIO_RES_CEX1,
		PIO_RES_CEX2,
		PIO_RES_ECI,
		PIO_RES_T0,
		PIO_RES_T1,
		PIO_RES_NONE
	} pio_res_e;

	// number of peripheral signals
	localparam int PIO_NSIG = 15;

	typedef logic [7:0] pio_byte_t;

endpackage

// ===== hdl/pio_port.sv
// How it works
// - analog pin loses pull-up, output driver and input receiver
// - latch register reads zero for every analog pin
// - mode bit zero selects analog, one selects digital
// - output-type one drives pad high or low from output value
// - output-type zero drives low only; value one leaves pad floating
// - weak pull-up on while cell floats, off while driven
// - global pull-up off bit disables every weak pull-up
// - digital pin read returns pad level, not driven value
// - per-pin drive strength bit, low strength after reset
// - mismatch when masked pin levels differ from masked expected levels
// - mismatch offered as interrupt source and idle wake source
// - port write stores a latch holding output value until next write
// - ordinary port read returns pin levels even for routed pins
// - read-modify-write reads the latch instead of the pins
// - port register written as whole byte or single bit
// - exclude bit keeps crossbar from assigning any function to a pin, except the fixed async pair on pins 4 and 5
// - route0 bit 7 routes external counter input
// - route0 bits 6:4 route none, one, two or three counter channels
// - route0 bit 3 routes system clock output
// - route0 bit 2 routes two-wire bus pair
// - route0 bit 1 routes serial peripheral, three or four pins
// - route0 bit 0 routes async serial pair to pins 4 and 5
// - route1 bit 6 enables the crossbar
// - all drivers stay off until the crossbar is enabled
// - route1 bits 1 and 0 route timer one and timer zero inputs
// - each resource after the fixed async pair takes lowest pin neither assigned nor excluded
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_port
	import pio_pkg::*;
#(
	parameter int PIN_COUNT = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_idx,
	input wire logic sfr_bit_val,
	input wire logic sfr_rd,
	input wire logic sfr_rmw,
	output logic [7:0] sfr_rdata,
	input wire logic spi_four_wire,
	input wire logic [PIO_NSIG-1:0] periph_out,
	output logic [PIO_NSIG-1:0] periph_in,
	input wire logic [PIN_COUNT-1:0] pad_in,
	output logic [PIN_COUNT-1:0] pad_out,
	output logic [PIN_COUNT-1:0] pad_oe_n,
	output logic [PIN_COUNT-1:0] pad_pullup_en,
	output logic [PIN_COUNT-1:0] pad_input_en,
	output logic [PIN_COUNT-1:0] pad_drive_high,
	output logic port_mismatch,
	output logic mismatch_pulse
);

	// the fixed async pair needs pins 4 and 5; registers are one byte wide
	if (PIN_COUNT < 6 || PIN_COUNT > 8) begin : g_bad_width
		$error("pio_port: PIN_COUNT must lie between 6 and 8");
	end

	// signal codes sit in four bits of the pin map, the top code meaning none
	if (PIO_NSIG > 15) begin : g_bad_map
		$error("pio_port: too many peripheral signals for the pin map");
	end

	typedef logic [PIN_COUNT-1:0] pio_pins_t;
	typedef logic [PIN_COUNT-1:0][3:0] pio_map_t;

	typedef struct packed {
		pio_pins_t latch;
		pio_pins_t adsel;
		pio_pins_t otype;
		pio_pins_t skip;
		pio_pins_t drv;
		pio_pins_t match;
		pio_pins_t mask;
		pio_byte_t route0;
		pio_byte_t route1;
		pio_pins_t pad_out;
		pio_pins_t pad_oe_n;
		pio_pins_t pad_pu;
		pio_pins_t pad_ie;
		pio_pins_t pad_dh;
		logic [PIO_NSIG-1:0] per_in;
		pio_byte_t rdata;
		logic mism;
		logic mism_pulse;
	} pio_state_s;

	pio_state_s s_reg;
	pio_state_s s_next;
	pio_pins_t pin_sync;

	// zero-extend a pin vector onto the byte bus
	function automatic pio_byte_t widen(input pio_pins_t v);
		widen = 8'(v);
	endfunction

	// take the pin bits of a bus byte; bits above the pins are dropped
	function automatic pio_pins_t narrow(input pio_byte_t b);
		narrow = b[PIN_COUNT-1:0];
	endfunction

	// pin vector seen through a select mask
	function automatic pio_pins_t masked(input pio_pins_t v, input pio_pins_t m);
		masked = v & m;
	endfunction

	// counter channels routed by the three-bit field; reserved codes route none
	function automatic logic [1:0] cex_count(input logic [2:0] code);
		unique case (code)
			3'h1: cex_count = 2'h1;
			3'h2: cex_count = 2'h2;
			3'h3: cex_count = 2'h3;
			default: cex_count = 2'h0;
		endcase
	endfunction

	// priority assignment of peripheral signals to pins
	// the async pair is fixed and ignores exclude bits; a resource
	// that finds no free pin is left unrouted
	function automatic pio_map_t xbar_map(
		input logic [PIO_NSIG-1:0] req,
		input pio_pins_t excl,
		input logic uart_on
	);
		pio_pins_t taken;
		logic found;
		xbar_map = '{default: 4'(PIO_RES_NONE)};
		taken = excl;
		if (uart_on) begin
			xbar_map[`PIO_UART_TX_PIN] = 4'(PIO_RES_TX);
			xbar_map[`PIO_UART_RX_PIN] = 4'(PIO_RES_RX);
			taken[`PIO_UART_TX_PIN] = 1'b1;
			taken[`PIO_UART_RX_PIN] = 1'b1;
		end
		// resources in priority order, each scanning up from pin zero
		// lowest free pin
		for (int r = int'(PIO_RES_SDA); r < PIO_NSIG; r++) begin
			found = 1'b0;
			for (int i = 0; i < PIN_COUNT; i++) begin
				if (req[r] && !found && !taken[i]) begin
					xbar_map[i] = 4'(r);
					taken[i] = 1'b1;
					found = 1'b1;
				end
			end
		end
	endfunction

	// pads come from outside the clock domain; the stages reset low so
	// the compare and the reads start from a known level
	// pad sync stages
	pio_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(pad_in),
		.q(pin_sync)
	);

	// next state: crossbar map, pad cells, compare and register access
	always_comb begin
		logic [PIO_NSIG-1:0] req;
		logic [2:0] cex;
		pio_map_t sel;
		pio_pins_t din;
		pio_pins_t ld;
		logic val;
		logic drv_lo;
		logic drv_hi;
		logic xbar_on;
		logic pu_off;
		req = '0;
		cex = '0;
		sel = '{default: 4'(PIO_RES_NONE)};
		din = '0;
		ld = '0;
		val = 1'b0;
		drv_lo = 1'b0;
		drv_hi = 1'b0;
		s_next = s_reg;
		xbar_on = s_reg.route1[`PIO_R1_XBAR];
		pu_off = s_reg.route1[`PIO_R1_PUOFF];

		// resource requests from the routing registers
		// a request only claims a pin; the drivers still wait for the enable
		cex = s_reg.route0[`PIO_R0_CEX_HI:`PIO_R0_CEX_LO];
		req[PIO_RES_SDA] = s_reg.route0[`PIO_R0_TWOWIRE];
		req[PIO_RES_SCL] = s_reg.route0[`PIO_R0_TWOWIRE];
		req[PIO_RES_SCK] = s_reg.route0[`PIO_R0_SPI];
		req[PIO_RES_MISO] = s_reg.route0[`PIO_R0_SPI];
		req[PIO_RES_MOSI] = s_reg.route0[`PIO_R0_SPI];
		req[PIO_RES_NSS] = s_reg.route0[`PIO_R0_SPI] & spi_four_wire;
		req[PIO_RES_SYSCLK] = s_reg.route0[`PIO_R0_SYSCK];
		// channel count, reserved codes route none
		req[PIO_RES_COUNTER_CHANNEL_OUTPUT] = (cex_count(cex) >= 2'h1);
		req[PIO_RES_CEX1] = (cex_count(cex) >= 2'h2);
		req[PIO_RES_CEX2] = (cex_count(cex) == 2'h3);
		req[PIO_RES_ECI] = s_reg.route0[`PIO_R0_ECI];
		req[PIO_RES_T0] = s_reg.route1[`PIO_R1_T0];
		req[PIO_RES_T1] = s_reg.route1[`PIO_R1_T1];
		sel = xbar_map(req, s_reg.skip, s_reg.route0[`PIO_R0_UART]);

		// analog receiver off, level reads zero
		din = masked(pin_sync, s_reg.adsel);

		// pad cell control per pin; the cell follows the registers one cycle late
		// because every pad control leaves a flop
		for (int i = 0; i < PIN_COUNT; i++) begin
			val = (sel[i] == 4'(PIO_RES_NONE)) ? s_reg.latch[i] : periph_out[sel[i]];
			// drivers held off until crossbar enabled
			drv_lo = xbar_on & s_reg.adsel[i] & ~val;
			drv_hi = xbar_on & s_reg.adsel[i] & s_reg.otype[i] & val;
			s_next.pad_out[i] = val;
			s_next.pad_oe_n[i] = ~(drv_lo | drv_hi);
			s_next.pad_pu[i] = s_reg.adsel[i] & ~pu_off & ~(drv_lo | drv_hi);
			s_next.pad_ie[i] = s_reg.adsel[i];
		end
		s_next.pad_dh = s_reg.drv;

		// routed pin levels back to peripherals; unrouted inputs idle high
		// so a peripheral with no pin sees an idle line
		s_next.per_in = '1;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (sel[i] != 4'(PIO_RES_NONE)) begin
				s_next.per_in[sel[i]] = din[i];
			end
		end

		// synchronised levels keep the event free of pad glitches
		// masked compare, routing ignored
		s_next.mism = (masked(din, s_reg.mask) != masked(s_reg.match, s_reg.mask));
		// level for interrupt, pulse for wake
		s_next.mism_pulse = s_next.mism & ~s_reg.mism;

		// register reads; a read in the same cycle as a write sees the old value
		// and the result stands until the next read
		if (sfr_rd) begin
			unique case (sfr_addr)
				`PIO_ADDR_LATCH: begin
					s_next.rdata = widen(sfr_rmw ? masked(s_reg.latch, s_reg.adsel) : din);
				end
				`PIO_ADDR_ROUTE0: s_next.rdata = s_reg.route0;
				`PIO_ADDR_ROUTE1: s_next.rdata = s_reg.route1;
				`PIO_ADDR_ADSEL: s_next.rdata = widen(s_reg.adsel);
				`PIO_ADDR_OTYPE: s_next.rdata = widen(s_reg.otype);
				`PIO_ADDR_SKIP: s_next.rdata = widen(s_reg.skip);
				`PIO_ADDR_DRV: s_next.rdata = widen(s_reg.drv);
				`PIO_ADDR_MATCH: s_next.rdata = widen(s_reg.match);
				`PIO_ADDR_MASK: s_next.rdata = widen(s_reg.mask);
				default: s_next.rdata = 8'h00;
			endcase
		end

		// register writes; reserved route1 bits are kept at zero
		if (sfr_wr) begin
			unique case (sfr_addr)
				`PIO_ADDR_LATCH: s_next.latch = narrow(sfr_wdata);
				`PIO_ADDR_ROUTE0: s_next.route0 = sfr_wdata;
				`PIO_ADDR_ROUTE1: s_next.route1 = sfr_wdata & `PIO_R1_WMASK;
				`PIO_ADDR_ADSEL: s_next.adsel = narrow(sfr_wdata);
				`PIO_ADDR_OTYPE: s_next.otype = narrow(sfr_wdata);
				`PIO_ADDR_SKIP: s_next.skip = narrow(sfr_wdata);
				`PIO_ADDR_DRV: s_next.drv = narrow(sfr_wdata);
				`PIO_ADDR_MATCH: s_next.match = narrow(sfr_wdata);
				`PIO_ADDR_MASK: s_next.mask = narrow(sfr_wdata);
				default: ;
			endcase
		end

		// a bit write lands over a byte write to the latch in the same cycle
		// single-bit latch write
		ld = s_next.latch;
		if (sfr_bit_wr && sfr_addr == `PIO_ADDR_LATCH && int'(sfr_bit_idx) < PIN_COUNT) begin
			ld[sfr_bit_idx] = sfr_bit_val;
		end
		s_next.latch = ld;
	end

	// state register, reset synchronously to the power-up configuration
	// outputs leave this register, so nothing combinational reaches a pin
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// read data, compare and drive strength clear
			s_reg <= '0;
			// configuration registers
			s_reg.latch <= narrow(`PIO_RST_LATCH);
			s_reg.adsel <= narrow(`PIO_RST_ADSEL);
			s_reg.otype <= narrow(`PIO_RST_OTYPE);
			s_reg.skip <= narrow(`PIO_RST_SKIP);
			s_reg.drv <= narrow(`PIO_RST_DRV);
			s_reg.match <= narrow(`PIO_RST_MATCH);
			s_reg.mask <= narrow(`PIO_RST_MASK);
			s_reg.route0 <= `PIO_RST_ROUTE0;
			s_reg.route1 <= `PIO_RST_ROUTE1;
			// cells idle high impedance with pull-ups and receivers on
			s_reg.pad_out <= '1;
			s_reg.pad_oe_n <= '1; // cells float after reset
			s_reg.pad_pu <= '1;
			s_reg.pad_ie <= '1;
			s_reg.per_in <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	// pad controls and compare results all carry one cycle of lag
	assign sfr_rdata = s_reg.rdata;
	assign periph_in = s_reg.per_in;
	assign pad_out = s_reg.pad_out;
	assign pad_oe_n = s_reg.pad_oe_n;
	assign pad_pullup_en = s_reg.pad_pu;
	assign pad_input_en = s_reg.pad_ie;
	assign pad_drive_high = s_reg.pad_dh;
	assign port_mismatch = s_reg.mism;
	assign mismatch_pulse = s_reg.mism_pulse;

endmodule

// ===== hdl/pio_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for pad levels
module pio_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pio_sync_s;

	pio_sync_s s_reg;
	pio_sync_s s_next;

	// stage1 feeds stage2 only
	always_comb begin
		s_next.stage1 = d;
		s_next.stage2 = s_reg.stage1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.stage2;

endmodule

// ===== testbench/pio_pad_model.sv
`timescale 1ns/1ps
// pads: cell drive wins, else resistive source, else pull-up, else floating
module pio_pad_model (
	input wire logic clk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_n,
	input wire logic [7:0] pad_pullup_en,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_lv,
	output logic [7:0] pad_in
);
	logic [7:0] flt_reg = 8'h00;
	// floating pads wander every cycle
	always_ff @(posedge clk) begin
		flt_reg <= ~flt_reg;
	end
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_lv)
		| (pad_oe_n & ~ext_en & (pad_pullup_en | flt_reg));
endmodule

// ===== testbench/pio_port_properties.sv
`timescale 1ns/1ps
`include "pio_cfg.svh"
module pio_port_properties
	import pio_pkg::*;
#(
	parameter int PIN_COUNT = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [PIN_COUNT-1:0] pad_out,
	input wire logic [PIN_COUNT-1:0] pad_oe_n,
	input wire logic [PIN_COUNT-1:0] pad_pullup_en,
	input wire logic [PIN_COUNT-1:0] pad_input_en,
	input wire logic [PIN_COUNT-1:0] pad_drive_high,
	input wire logic port_mismatch,
	input wire logic mismatch_pulse
);
	logic [PIN_COUNT-1:0] mode_reg;
	logic [PIN_COUNT-1:0] otype_reg;
	logic [1:0] r1_reg;
	// mirror of mode, output type and route1 bits 7:6
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_reg <= '1;
			otype_reg <= '0;
			r1_reg <= 2'h0;
		end else if (sfr_wr) begin
			if (sfr_addr == `PIO_ADDR_ADSEL) begin
				mode_reg <= sfr_wdata[PIN_COUNT-1:0];
			end
			if (sfr_addr == `PIO_ADDR_OTYPE) begin
				otype_reg <= sfr_wdata[PIN_COUNT-1:0];
			end
			if (sfr_addr == `PIO_ADDR_ROUTE1) begin
				r1_reg <= sfr_wdata[7:6];
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_mm_rise;
		!port_mismatch ##1 port_mismatch;
	endsequence
	a_analog_cell_off: assert property ((~pad_input_en & (pad_pullup_en | ~pad_oe_n)) == '0)
		else $error("analog pin still active");
	a_mode_to_rx: assert property (pad_input_en == $past(mode_reg))
		else $error("receiver enable wrong");
	a_od_no_high: assert property ((~pad_oe_n & pad_out & ~$past(otype_reg)) == '0)
		else $error("open-drain pin driven high");
	a_low_no_pull: assert property ((~pad_oe_n & ~pad_out & pad_pullup_en) == '0)
		else $error("pull-up on while driven low");
	a_pull_global: assert property ($past(r1_reg[1]) |-> pad_pullup_en == '0)
		else $error("pull-up on while globally off");
	a_xbar_off: assert property (!$past(r1_reg[0]) |-> &pad_oe_n)
		else $error("driver on with crossbar off");
	a_drv_cause: assert property ($changed(pad_drive_high) |->
		$past(sfr_wr, 2) && $past(sfr_addr, 2) == `PIO_ADDR_DRV)
		else $error("drive strength changed unasked");
	a_mm_pulse: assert property (s_mm_rise |-> mismatch_pulse ##1 !mismatch_pulse)
		else $error("mismatch pulse missing");
	a_pulse_cause: assert property (mismatch_pulse |-> $rose(port_mismatch))
		else $error("stray mismatch pulse");
endmodule

bind pio_port pio_port_properties #(.PIN_COUNT(PIN_COUNT)) u_pio_port_properties (
	.clk(clk),
	.sys_rst(sys_rst),
	.sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata),
	.pad_out(pad_out),
	.pad_oe_n(pad_oe_n),
	.pad_pullup_en(pad_pullup_en),
	.pad_input_en(pad_input_en),
	.pad_drive_high(pad_drive_high),
	.port_mismatch(port_mismatch),
	.mismatch_pulse(mismatch_pulse)
);

// ===== testbench/tb.sv
`timescale 1ns/1ps
`include "pio_cfg.svh"
module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
	logic [2:0] sfr_bit_idx = 3'h0;
	logic [14:0] periph_out = 15'h7fff;
	logic [14:0] periph_in;
	logic [7:0] sfr_rdata, pad_in, pad_out, pad_oe_n, pad_pullup_en, pad_input_en, pad_drive_high;
	logic port_mismatch, mismatch_pulse;
	logic [7:0] e_en = 8'h00, e_lv = 8'h00;
	logic [7:0] m_lat, m_mode, m_ot, m_drv, m_mask, m_match, dl, dh, pad, d;
	logic [2:0] bi;
	logic [14:0] ex;
	logic spi4 = 1'b0;
	int failures = 0, samples_checked = 0;
	integer seed = 32'ha52f_2008;
	// route0, route1, exclude, signal index, expected pin (8 means none), four-wire
	int tab[15][6] = '{'{1, 64, 0, 0, 4, 0}, '{4, 64, 0, 2, 0, 0}, '{4, 64, 3, 2, 2, 0},
		'{4, 64, 0, 3, 1, 0}, '{2, 64, 0, 4, 0, 0}, '{8, 64, 0, 8, 0, 0}, '{16, 64, 0, 9, 0, 0},
		'{48, 64, 0, 11, 2, 0}, '{64, 64, 0, 9, 8, 0}, '{2, 64, 0, 7, 8, 0}, '{2, 64, 0, 7, 3, 1},
		'{128, 64, 0, 12, 0, 0}, '{0, 65, 0, 13, 0, 0}, '{0, 67, 0, 14, 1, 0}, '{5, 64, 1, 3, 2, 0}};
	pio_port #(.PIN_COUNT(8)) u_pio_port (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx),
		.sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
		.spi_four_wire(spi4), .periph_out(periph_out), .periph_in(periph_in), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
		.pad_input_en(pad_input_en), .pad_drive_high(pad_drive_high),
		.port_mismatch(port_mismatch), .mismatch_pulse(mismatch_pulse));
	pio_pad_model u_pio_pad_model (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pad_pullup_en(pad_pullup_en), .ext_en(e_en), .ext_lv(e_lv), .pad_in(pad_in));
	// clock and watchdog
	initial forever #5 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		finish_test();
	end
	task automatic finish_test();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		tick(1);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
	endtask
	task automatic bw(input logic [2:0] i, input logic v);
		tick(1);
		sfr_addr = `PIO_ADDR_LATCH;
		sfr_bit_idx = i;
		sfr_bit_val = v;
		sfr_bit_wr = 1'b1;
		tick(1);
		sfr_bit_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic r);
		tick(1);
		sfr_addr = a;
		sfr_rmw = r;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		sfr_rmw = 1'b0;
		d = sfr_rdata;
	endtask
	initial begin
		tick(20);
		sys_rst = 1'b0;
		// reset values, unmapped address, crossbar off, reserved bits
		rd(`PIO_ADDR_ROUTE0, 1'b0); chk(d, 8'h00);
		rd(`PIO_ADDR_ROUTE1, 1'b0); chk(d, 8'h00);
		rd(8'h00, 1'b0); chk(d, 8'h00);
		wr(`PIO_ADDR_LATCH, 8'h00); tick(3); chk(pad_oe_n, 8'hff);
		wr(`PIO_ADDR_ROUTE1, 8'hff); rd(`PIO_ADDR_ROUTE1, 1'b0); chk(d, 8'hc3);
		tick(2); chk(pad_pullup_en, 8'h00);
		wr(`PIO_ADDR_ROUTE1, 8'h40);
		// random pin configurations against the reference model
		repeat (40) begin
			m_mode = 8'($random(seed)); m_ot = 8'($random(seed)); m_drv = 8'($random(seed));
			m_mask = 8'($random(seed)); m_match = 8'($random(seed)); m_lat = 8'($random(seed));
			e_en = 8'($random(seed)); e_lv = 8'($random(seed)); bi = 3'($random(seed));
			wr(`PIO_ADDR_ADSEL, m_mode); wr(`PIO_ADDR_OTYPE, m_ot); wr(`PIO_ADDR_DRV, m_drv);
			wr(`PIO_ADDR_MASK, m_mask); wr(`PIO_ADDR_MATCH, m_match); wr(`PIO_ADDR_LATCH, m_lat);
			bw(bi, ~m_lat[bi]);
			m_lat[bi] = ~m_lat[bi];
			tick(6);
			dl = m_mode & ~m_lat;
			dh = m_mode & m_ot & m_lat;
			pad = dh | (~dl & ~dh & ((e_en & e_lv) | ~e_en));
			chk(pad_oe_n, ~(dl | dh));
			chk(pad_pullup_en, m_mode & ~dl & ~dh);
			chk(pad_input_en, m_mode);
			chk(pad_drive_high, m_drv);
			chk(pad_out, m_lat);
			chk({7'h0, port_mismatch}, {7'h0, (pad & m_mode & m_mask) != (m_match & m_mask)});
			rd(`PIO_ADDR_LATCH, 1'b0); chk(d, pad & m_mode);
			rd(`PIO_ADDR_LATCH, 1'b1); chk(d, m_lat & m_mode);
		end
		// crossbar routing table
		e_en = 8'h00;
		wr(`PIO_ADDR_ADSEL, 8'hff); wr(`PIO_ADDR_OTYPE, 8'h00); wr(`PIO_ADDR_LATCH, 8'hff);
		foreach (tab[i]) begin
			spi4 = tab[i][5] != 0;
			wr(`PIO_ADDR_SKIP, 8'(tab[i][2])); wr(`PIO_ADDR_ROUTE1, 8'(tab[i][1]));
			wr(`PIO_ADDR_ROUTE0, 8'(tab[i][0]));
			periph_out = ~(15'h1 << tab[i][3]);
			ex = (tab[i][4] == 8) ? 15'h7fff : periph_out;
			tick(4);
			chk(pad_oe_n, ~(8'h01 << tab[i][4]));
			rd(`PIO_ADDR_LATCH, 1'b0); chk(d, ~(8'h01 << tab[i][4]));
			chk(periph_in[7:0], ex[7:0]);
			chk({1'b0, periph_in[14:8]}, {1'b0, ex[14:8]});
			periph_out = 15'h7fff;
		end
		finish_test();
	end
endmodule
